// *** logic/fcd_pkg.sv ***
// Constants for the mode setup and parameter dump command block
package fcd_pkg;
   // ------------------------------------------------------------
   // Register port offsets
   // ------------------------------------------------------------
   localparam logic [1:0] FCD_ADDR_DATA = 2'h0;
   localparam logic [1:0] FCD_ADDR_STATUS = 2'h1;
   // ------------------------------------------------------------
   // Opcodes and byte counts
   // ------------------------------------------------------------
   localparam logic [7:0] FCD_OP_SETUP = 8'h13;
   localparam logic [7:0] FCD_OP_DUMP = 8'h0E;
   localparam logic [3:0] FCD_DUMP_LEN = 4'hA;
   localparam logic [3:0] FCD_DUMP_LAST = 4'h9;
   // ------------------------------------------------------------
   // Third setup byte field positions and the dump byte eight lock bit
   // ------------------------------------------------------------
   localparam int FCD_BIT_ISEEK = 6;
   localparam int FCD_BIT_FIFO = 5;
   localparam int FCD_BIT_POLL = 4;
   localparam int FCD_THR_HI = 3;
   localparam int FCD_LOCK_BIT = 7;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [3:0] FCD_THR_RST = 4'h0;
   localparam logic FCD_FIFO_DIS_RST = 1'b1;
   localparam logic FCD_POLL_DIS_RST = 1'b0;
   localparam logic FCD_ISEEK_RST = 1'b0;
   localparam logic [7:0] FCD_PCOMP_RST = 8'h00;
   // ------------------------------------------------------------
   // Timing: polling window after reset
   // ------------------------------------------------------------
   localparam int FCD_CLK_PERIOD_NS = 10;
   localparam int FCD_POLL_WIN_MS = 500;
   localparam int FCD_POLL_WIN_CYC = FCD_POLL_WIN_MS * 1000000
                                     / FCD_CLK_PERIOD_NS;
   localparam int FCD_WIN_W = 26;
   // ------------------------------------------------------------
   // Command sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      FCD_IDLE,
      FCD_CFG_B2,
      FCD_CFG_B3,
      FCD_CFG_B4,
      FCD_DUMP
   } fcd_state_e;
endpackage : fcd_pkg

// *** logic/fcd_config_dump.sv ***
// Mode setup command and parameter dump command handler
//
// Notes on behaviour
// - Setup: opcode, zero byte, enables plus threshold, precomp track.
// - Hardware reset returns all setup fields to defaults, ignoring lock.
// - Threshold takes 00h to 0Fh and drives transfer FIFO threshold.
// - Soft reset clears threshold unless lock is set.
// - Polling disable defaults 0; soft reset clears it.
// - With polling enabled an interrupt follows reset.
// - Polling disabled within 500 ms of reset suppresses that interrupt.
// - FIFO disable defaults 1; soft reset sets it unless locked.
// - Implied seek enable defaults 0, soft reset clears; mode bit ORs in.
// - Implied seeks enabled: seek requested before each data operation.
// - Precomp track 00h to FFh; soft reset zeroes it unless locked.
// - Setup only writes internal registers; no result bytes.
// - Dump: one opcode byte, then exactly ten result bytes.
// - Dump bytes one to four: present track of drives 0 to 3.
// - Dump bytes five, six: step rate, delays and DMA bit.
// - Byte seven: sectors per track after format, else end of track.
// - Bytes nine, ten: current setup fields (bit 7 zero) and precomp track.
// - Hardware reset defaults all; soft reset keeps locked fields.
// - Byte eight: lock at bit 7, drive configuration in bits 5-0.
// - Lock set: guarded fields survive soft reset; clear: defaults.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module fcd_config_dump #(
   parameter int POLL_WIN_CYCLES = fcd_pkg::FCD_POLL_WIN_CYC
) (
   // Clock and resets
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic soft_reset_in,
   // Register port
   input wire logic [1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // Parameters kept by other command logic
   input wire logic lock_in,
   input wire logic [31:0] present_track_number_in,
   input wire logic [3:0] step_rate_time_in,
   input wire logic [3:0] delay_after_processing_in,
   input wire logic [6:0] delay_before_processing_in,
   input wire logic dma_mode_in,
   input wire logic [7:0] sectors_per_track_in,
   input wire logic [7:0] end_of_track_sector_in,
   input wire logic [3:0] per_drive_configuration_in,
   input wire logic [1:0] group_drive_configuration_in,
   // Command events from the rest of the controller
   input wire logic format_cmd_in,
   input wire logic rw_cmd_in,
   input wire logic data_op_start_in,
   input wire logic drive_mode_implied_seek_bit_in,
   input wire logic irq_ack_in,
   // Setup values, implied seek request and reset interrupt to the controller
   output logic [3:0] fifo_threshold_out,
   output logic fifo_disable_out,
   output logic polling_disable_out,
   output logic implied_seek_enable_out,
   output logic [7:0] precomp_start_track_out,
   output logic implied_seek_req_out,
   output logic reset_irq_out
);
   import fcd_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      fcd_state_e state;
      logic [3:0] idx;
      logic [9:0][7:0] snap;
      logic [7:0] cfg_tmp;
      logic [3:0] thr;
      logic fifo_dis;
      logic poll_dis;
      logic iseek;
      logic [7:0] pcomp;
      logic fmt_last;
      logic [FCD_WIN_W-1:0] win_cnt;
      logic win_run;
      logic irq;
      logic seek_req;
      logic [7:0] rdata;
   } fcd_state_s;

   fcd_state_s st_reg;
   fcd_state_s st_next;

   localparam logic [FCD_WIN_W-1:0] WIN_LOAD =
      FCD_WIN_W'(POLL_WIN_CYCLES);

   function automatic logic [7:0] fcd_cfg_byte(input logic iseek,
                                               input logic fdis,
                                               input logic pdis,
                                               input logic [3:0] thr);
      fcd_cfg_byte = {1'b0, iseek, fdis, pdis, thr};
   endfunction : fcd_cfg_byte

   logic wr_data;
   logic rd_data;
   logic rd_status;
   assign wr_data = wr_in && (addr_in == FCD_ADDR_DATA);
   assign rd_data = rd_in && (addr_in == FCD_ADDR_DATA);
   assign rd_status = rd_in && (addr_in == FCD_ADDR_STATUS);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.rdata = 8'h00;
      st_next.seek_req = 1'b0;
      // Read or write ran later than format
      if (rw_cmd_in) begin
         st_next.fmt_last = 1'b0;
      end else if (format_cmd_in) begin
         st_next.fmt_last = 1'b1;
      end
      // Combined enable: mode bit can turn seeks on alone
      if (data_op_start_in &&
          (st_reg.iseek || drive_mode_implied_seek_bit_in)) begin
         st_next.seek_req = 1'b1;
      end
      // Polling window count-down
      if (st_reg.win_run) begin
         if (st_reg.win_cnt <= {{(FCD_WIN_W-1){1'b0}}, 1'b1}) begin
            st_next.win_run = 1'b0;
            if (!st_reg.poll_dis) begin
               st_next.irq = 1'b1;
            end
         end else begin
            st_next.win_cnt = st_reg.win_cnt - 1'b1;
         end
      end
      // Set wins over acknowledge
      if (irq_ack_in && !(st_next.irq && !st_reg.irq)) begin
         st_next.irq = 1'b0;
      end
      case (st_reg.state)
         FCD_IDLE: begin
            if (wr_data && wdata_in == FCD_OP_SETUP) begin
               st_next.state = FCD_CFG_B2;
            end else if (wr_data && wdata_in == FCD_OP_DUMP) begin
               // Snapshot at opcode keeps the ten bytes coherent
               st_next.state = FCD_DUMP;
               st_next.idx = 4'h0;
               for (int i = 0; i < 4; i++) begin
                  st_next.snap[i] =
                     present_track_number_in[i*8 +: 8];
               end
               st_next.snap[4] = {step_rate_time_in,
                                  delay_after_processing_in};
               st_next.snap[5] = {delay_before_processing_in,
                                  dma_mode_in};
               st_next.snap[6] = st_reg.fmt_last ?
                  sectors_per_track_in : end_of_track_sector_in;
               st_next.snap[7] = {lock_in, 1'b0,
                                  per_drive_configuration_in,
                                  group_drive_configuration_in};
               st_next.snap[8] = fcd_cfg_byte(st_reg.iseek,
                  st_reg.fifo_dis, st_reg.poll_dis, st_reg.thr);
               st_next.snap[9] = st_reg.pcomp;
            end
         end
         FCD_CFG_B2: begin
            // Second byte is all zero by protocol; content not checked
            if (wr_data) begin
               st_next.state = FCD_CFG_B3;
            end
         end
         FCD_CFG_B3: begin
            if (wr_data) begin
               st_next.cfg_tmp = wdata_in;
               st_next.state = FCD_CFG_B4;
            end
         end
         FCD_CFG_B4: begin
            if (wr_data) begin
               // Fields commit together; no result phase follows
               st_next.iseek = st_reg.cfg_tmp[FCD_BIT_ISEEK];
               st_next.fifo_dis = st_reg.cfg_tmp[FCD_BIT_FIFO];
               st_next.poll_dis = st_reg.cfg_tmp[FCD_BIT_POLL];
               st_next.thr = st_reg.cfg_tmp[FCD_THR_HI:0];
               st_next.pcomp = wdata_in;
               st_next.state = FCD_IDLE;
               if (st_reg.cfg_tmp[FCD_BIT_POLL] && st_reg.win_run) begin
                  st_next.win_run = 1'b0;
               end
            end
         end
         FCD_DUMP: begin
            // Writes here are dropped; host drains results first
            if (rd_data) begin
               st_next.rdata = st_reg.snap[st_reg.idx];
               if (st_reg.idx == FCD_DUMP_LAST) begin
                  st_next.state = FCD_IDLE;
               end else begin
                  st_next.idx = st_reg.idx + 4'h1;
               end
            end
         end
         default: begin
            st_next.state = FCD_IDLE;
         end
      endcase
      if (rd_status) begin
         st_next.rdata = {(st_reg.state == FCD_DUMP),
                          (st_reg.state != FCD_IDLE), 2'b00,
                          FCD_DUMP_LEN - st_reg.idx};
      end
      // Soft reset: lock guards threshold, FIFO and precomp only
      if (soft_reset_in) begin
         st_next.state = FCD_IDLE;
         st_next.idx = 4'h0;
         st_next.poll_dis = FCD_POLL_DIS_RST;
         st_next.iseek = FCD_ISEEK_RST;
         st_next.win_cnt = WIN_LOAD;
         st_next.win_run = 1'b1;
         if (!lock_in) begin
            st_next.thr = FCD_THR_RST;
            st_next.fifo_dis = FCD_FIFO_DIS_RST;
            st_next.pcomp = FCD_PCOMP_RST;
         end else begin
            // Locked fields hold even if a setup commits this cycle
            st_next.thr = st_reg.thr;
            st_next.fifo_dis = st_reg.fifo_dis;
            st_next.pcomp = st_reg.pcomp;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_reg <= '0;
         st_reg.state <= FCD_IDLE;
         st_reg.thr <= FCD_THR_RST;
         st_reg.fifo_dis <= FCD_FIFO_DIS_RST;
         st_reg.poll_dis <= FCD_POLL_DIS_RST;
         st_reg.iseek <= FCD_ISEEK_RST;
         st_reg.pcomp <= FCD_PCOMP_RST;
         st_reg.win_cnt <= WIN_LOAD;
         st_reg.win_run <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata_out = st_reg.rdata;
   assign fifo_threshold_out = st_reg.thr;
   assign fifo_disable_out = st_reg.fifo_dis;
   assign polling_disable_out = st_reg.poll_dis;
   assign implied_seek_enable_out = st_reg.iseek;
   assign precomp_start_track_out = st_reg.pcomp;
   assign implied_seek_req_out = st_reg.seek_req;
   assign reset_irq_out = st_reg.irq;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   logic commit;
   assign commit = (st_reg.state == FCD_CFG_B4) && wr_data &&
                   !soft_reset_in;

   a_setup_commit: assert property (
      commit |=> (precomp_start_track_out == $past(wdata_in)) &&
                 (implied_seek_enable_out == $past(st_reg.cfg_tmp[6])))
      else $error("setup bytes not committed");
   a_fifo_threshold_load: assert property (
      commit |=> fifo_threshold_out == $past(st_reg.cfg_tmp[3:0]))
      else $error("threshold not loaded");
   a_soft_unlocked: assert property (
      soft_reset_in && !lock_in |=> fifo_threshold_out == 4'h0 &&
         fifo_disable_out && precomp_start_track_out == 8'h00)
      else $error("soft reset left guarded field");
   a_soft_locked: assert property (
      soft_reset_in && lock_in |=> $stable(fifo_threshold_out) &&
         $stable(fifo_disable_out) && $stable(precomp_start_track_out))
      else $error("locked field changed on soft reset");
   a_soft_clears: assert property (
      soft_reset_in |=> !polling_disable_out && !implied_seek_enable_out)
      else $error("soft reset did not clear enables");
   a_poll_irq: assert property (
      st_reg.win_run && st_reg.win_cnt == 1 && !st_reg.poll_dis &&
      !soft_reset_in |=> reset_irq_out)
      else $error("no interrupt after window");
   a_poll_cancel: assert property (
      commit && st_reg.cfg_tmp[FCD_BIT_POLL] |=> !st_reg.win_run)
      else $error("window not cancelled");
   a_no_result: assert property (
      commit |=> st_reg.state == FCD_IDLE ##1 rdata_out == 8'h00)
      else $error("setup produced result");
   a_dump_start: assert property (
      st_reg.state == FCD_IDLE && wr_data && wdata_in == FCD_OP_DUMP &&
      !soft_reset_in |=> st_reg.state == FCD_DUMP && st_reg.idx == 0)
      else $error("dump did not start");
   a_dump_cfg: assert property (
      st_reg.state == FCD_IDLE && wr_data && wdata_in == FCD_OP_DUMP &&
      !soft_reset_in |=> st_reg.snap[8] == $past(fcd_cfg_byte(st_reg.iseek,
         st_reg.fifo_dis, st_reg.poll_dis, st_reg.thr)))
      else $error("dump byte nine wrong");
   a_snap_stable: assert property (
      st_reg.state == FCD_DUMP && $past(st_reg.state) == FCD_DUMP |->
         $stable(st_reg.snap))
      else $error("snapshot changed in dump");
   a_seek_req: assert property (
      data_op_start_in && st_reg.iseek |=> implied_seek_req_out)
      else $error("implied seek not requested");
   a_mode_seek: assert property (
      data_op_start_in && drive_mode_implied_seek_bit_in |=>
         implied_seek_req_out)
      else $error("mode bit seek not requested");

   a_fmt_select: assert property (
      rw_cmd_in |=> !st_reg.fmt_last)
      else $error("read or write did not select end of track");
   a_irq_sticky: assert property (
      reset_irq_out && !irq_ack_in |=> reset_irq_out)
      else $error("interrupt dropped without acknowledge");
   a_status_busy: assert property (
      st_reg.state == FCD_DUMP && rd_status && !soft_reset_in |=>
         rdata_out[7])
      else $error("status lost dump flag");

   // ------------------------------------------------------------
   // Cover points
   // ------------------------------------------------------------
   c_seek: cover property (implied_seek_req_out);

   c_setup: cover property (commit);
   c_dump_end: cover property (st_reg.state == FCD_DUMP &&
      st_reg.idx == FCD_DUMP_LAST && rd_data);
   c_irq: cover property (!reset_irq_out ##1 reset_irq_out);
   c_soft_lock: cover property (soft_reset_in && lock_in);
endmodule : fcd_config_dump

// *** dv/fcd_host_model.sv ***
// Host-side bus model that issues command bytes and reads results
`timescale 1ns/1ps
module fcd_host_model (
   // Clock
   input wire logic clk_in,
   // Controller data port
   input wire logic [7:0] rdata_in,
   output logic [1:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   import fcd_pkg::*;
   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   initial begin
      addr_out = 2'h3;
      wdata_out = 8'h5_A;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // One byte per strobe; idle lines show the inverse, not the last value
   task automatic wr_byte(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask : wr_byte
   task automatic rd_byte(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      #1 d = rdata_in;
   endtask : rd_byte
   // Four bytes strictly in order; second byte always zero
   task automatic setup(input logic [7:0] b3, input logic [7:0] b4);
      wr_byte(FCD_ADDR_DATA, FCD_OP_SETUP);
      wr_byte(FCD_ADDR_DATA, 8'h00);
      wr_byte(FCD_ADDR_DATA, b3);
      wr_byte(FCD_ADDR_DATA, b4);
   endtask : setup
endmodule : fcd_host_model

// *** dv/fdc_config_and_param_dump_tb.sv ***
// Self-checking bench for the setup and dump command block
`timescale 1ns/1ps
module fdc_config_and_param_dump_tb;
   import fcd_pkg::*;
   // ------------------------------------------------------------
   // Signals and model state
   // ------------------------------------------------------------
   localparam int WIN = 20;
   logic clk_in = 1'b0, reset_n_in = 1'b0, soft_reset_in = 1'b0;
   logic [1:0] addr;
   logic [7:0] wdata, rdata_out, ptk, got;
   logic wr, rd, fdis, pdis, iseek, sreq, irq;
   logic [3:0] fth;
   logic lock_in = 1'b0, dma = 1'b0, fmt = 1'b0, rwc = 1'b0;
   logic op = 1'b0, mode_seek = 1'b0, ack = 1'b0;
   logic [31:0] ptr = 32'h0, seed;
   logic [3:0] step_t = 4'h0, daft = 4'h0, pdc = 4'h0;
   logic [6:0] dbef = 7'h00;
   logic [7:0] spt = 8'h00, end_trk = 8'h00, e [10];
   logic [1:0] grp_cfg = 2'h0;
   int errors = 0, check_count = 0, cycles = 0;
   int m_thr = 0, m_fdis = 1, m_pdis = 0, m_iseek = 0, m_trk = 0, m_spt = 0;
   always #5 clk_in = ~clk_in;
   fcd_config_dump #(.POLL_WIN_CYCLES(WIN)) fcd_config_dump_i (
      .clk_in(clk_in), .reset_n_in(reset_n_in),
      .soft_reset_in(soft_reset_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out), .lock_in(lock_in),
      .present_track_number_in(ptr), .step_rate_time_in(step_t),
      .delay_after_processing_in(daft), .delay_before_processing_in(dbef),
      .dma_mode_in(dma), .sectors_per_track_in(spt),
      .end_of_track_sector_in(end_trk), .per_drive_configuration_in(pdc),
      .group_drive_configuration_in(grp_cfg), .format_cmd_in(fmt),
      .rw_cmd_in(rwc), .data_op_start_in(op),
      .drive_mode_implied_seek_bit_in(mode_seek), .irq_ack_in(ack),
      .fifo_threshold_out(fth), .fifo_disable_out(fdis),
      .polling_disable_out(pdis), .implied_seek_enable_out(iseek),
      .precomp_start_track_out(ptk), .implied_seek_req_out(sreq),
      .reset_irq_out(irq));
   fcd_host_model fcd_host_model_i (.clk_in(clk_in), .rdata_in(rdata_out),
      .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic give_verdict();
      $display("Checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
      check_count++;
      if (g !== x) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic chk_outs();
      chk("threshold", m_thr, {4'h0, fth});
      chk("fifo disable", m_fdis, {7'h0, fdis});
      chk("poll disable", m_pdis, {7'h0, pdis});
      chk("seek enable", m_iseek, {7'h0, iseek});
      chk("precomp track", m_trk, ptk);
   endtask : chk_outs
   task automatic cfg(input logic [7:0] b3, input logic [7:0] b4);
      fcd_host_model_i.setup(b3, b4);
      m_iseek = b3[FCD_BIT_ISEEK];
      m_fdis = b3[FCD_BIT_FIFO];
      m_pdis = b3[FCD_BIT_POLL];
      m_thr = b3[FCD_THR_HI:0];
      m_trk = b4;
      #1;
   endtask : cfg
   task automatic soft_rst(input logic lk);
      @(posedge clk_in);
      lock_in <= lk;
      soft_reset_in <= 1'b1;
      @(posedge clk_in);
      soft_reset_in <= 1'b0;
      m_pdis = 0;
      m_iseek = 0;
      if (!lk) begin
         m_thr = 0;
         m_fdis = 1;
         m_trk = 0;
      end
      #1;
   endtask : soft_rst
   task automatic irq_wait(input logic x);
      logic seen;
      seen = 1'b0;
      repeat (WIN + 10) begin
         @(posedge clk_in);
         #1 seen = seen | irq;
      end
      chk("reset irq", {7'h0, x}, {7'h0, seen});
   endtask : irq_wait
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         give_verdict();
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      seed = 32'ha65f_25f2;
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      #1 chk_outs();
      irq_wait(1'b1);
      @(posedge clk_in);
      ack <= 1'b1;
      @(posedge clk_in);
      ack <= 1'b0;
      #1 chk("irq ack", 8'h00, {7'h0, irq});
      soft_rst(1'b0);
      cfg(8'h1F, 8'hFF);
      irq_wait(1'b0);
      chk_outs();
      fcd_host_model_i.rd_byte(FCD_ADDR_DATA, got);
      chk("no result", 8'h00, got);
      fcd_host_model_i.rd_byte(2'h2, got);
      chk("unmapped", 8'h00, got);
      for (int i = 0; i < 4; i++) begin
         cfg({1'b0, 7'($random(seed))}, 8'($random(seed)));
         chk_outs();
         soft_rst(i[0]);
         chk_outs();
      end
      for (int k = 0; k < 3; k++) begin
         cfg({1'b0, 7'($random(seed))}, 8'($random(seed)));
         @(posedge clk_in);
         {ptr, step_t, daft, dbef, dma} <= {$random(seed),
                                            16'($random(seed))};
         {spt, end_trk, pdc, grp_cfg, lock_in} <= 23'($random(seed));
         fmt <= (k != 0);
         rwc <= (k == 2);
         @(posedge clk_in);
         fmt <= 1'b0;
         rwc <= 1'b0;
         m_spt = (k == 1);
         #1;
         e = '{ptr[7:0], ptr[15:8], ptr[23:16], ptr[31:24], {step_t, daft},
                {dbef, dma}, m_spt ? spt : end_trk,
                {lock_in, 1'b0, pdc, grp_cfg},
                8'(m_iseek * 64 + m_fdis * 32 + m_pdis * 16 + m_thr),
                8'(m_trk)};
         fcd_host_model_i.wr_byte(FCD_ADDR_DATA, FCD_OP_DUMP);
         ptr <= ~ptr;
         spt <= ~spt;
         end_trk <= ~end_trk;
         fcd_host_model_i.wr_byte(FCD_ADDR_DATA, FCD_OP_SETUP);
         for (int i = 0; i < 10; i++) begin
            fcd_host_model_i.rd_byte(FCD_ADDR_DATA, got);
            chk("dump byte", e[i], got);
         end
         fcd_host_model_i.rd_byte(FCD_ADDR_DATA, got);
         chk("after dump", 8'h00, got);
         chk_outs();
      end
      for (int j = 0; j < 4; j++) begin
         cfg({1'b0, j[0], 6'h21}, 8'h10);
         @(posedge clk_in);
         op <= 1'b1;
         mode_seek <= j[1];
         @(posedge clk_in);
         op <= 1'b0;
         #1 chk("seek req", 8'(j != 0), {7'h0, sreq});
      end
      // Hardware reset with lock set must still restore every default
      @(posedge clk_in);
      lock_in <= 1'b1;
      reset_n_in <= 1'b0;
      @(posedge clk_in);
      reset_n_in <= 1'b1;
      m_thr = 0;
      m_fdis = 1;
      m_pdis = 0;
      m_iseek = 0;
      m_trk = 0;
      #1 chk_outs();
      give_verdict();
   end
endmodule : fdc_config_and_param_dump_tb
